// ==== src/see_pkg.sv ====
// Shared constants and carrier types of the serial memory bus slave
package see_pkg;

  // ************************************************************
  // Clock rates and printed timing figures
  // ************************************************************
  localparam int CLK_HZ = 50_000_000;
  localparam int LINK_HZ = 8_000_000;
  localparam int GLITCH_FILTER_WIDTH_NS = 100;
  localparam int POWERUP_READY_DELAY_MS = 1;
  localparam int INTERNAL_WRITE_TIME_MS = 5;
  localparam int FASTPLUS_SCL_HZ = 1_000_000;
  localparam int FAST_SCL_HZ = 400_000;
  localparam int MIN_OVERSAMPLE = 8;

  // Longest times round down, never below one cycle
  localparam int PU_CYC = POWERUP_READY_DELAY_MS * (CLK_HZ / 1000);
  localparam int WR_CYC = INTERNAL_WRITE_TIME_MS * (CLK_HZ / 1000);
  // A change must outlast the filter width to be believed; a pulse no wider than the
  // filter can land in at most this many samples less one, so round up then add one
  localparam int FILT_CYC = (GLITCH_FILTER_WIDTH_NS * (LINK_HZ / 1_000_000) + 999) / 1000 + 1;

  // ************************************************************
  // Address byte layout
  // ************************************************************
  localparam logic [3:0] DEV_CODE = 4'hA;
  localparam logic [2:0] FIXED_SEL = 3'h0;
  localparam int DATA_IDX = 2;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ACK_ADDR = 3'b010,
    ST_RX = 3'b011,
    ST_ACK_RX = 3'b100,
    ST_TX = 3'b101,
    ST_TX_ACK = 3'b110
  } see_state_t;

  typedef struct packed {
    logic scl;
    logic sda_in;
    logic wp;
    logic addr_select_bit2;
    logic addr_select_bit1;
    logic addr_select_bit0;
  } see_pins_t;

  typedef struct packed {
    logic [7:0] data;
    logic is_data;
  } see_rx_t;

endpackage

// ==== src/see_bus_slave.sv ====
// Bus-facing control of the two-wire serial memory slave
// Summary of operation
// R1: Fast-plus 1 MHz only on the later revision; master keeps within speed class.
// R2: Pulses up to 100 ns on clock and data inputs are ignored.
// R3: Logic held in reset while supply is low; standby once it rises.
// R4: Ready for commands at most 1 ms after supply is stable.
// R5: Data line is only pulled low; a one is sent by releasing it.
// R6: Data sampled on clock rise, launched after clock fall.
// R7: Respond only when three select bits match the strapped levels.
// R8: Variant without address pins uses a fixed internal selection.
// R9: Write protect high refuses writes; low or open has no effect.
// R10: Variant without write protect pin accepts all writes.
// R11: Internal write cycle, started by stop, completes within 5 ms. A repeated start that ends a write also starts it here.
// R12: Address byte is fixed pattern, three select bits, then direction bit.
// R13: Protect sampled on last clock fall before first data byte; high means no ack.
// R14: During an internal write cycle no request is acknowledged.
// R15: On the ninth clock the receiver acknowledges by pulling data low.
module see_bus_slave #(
  parameter int PU_CYCLES = see_pkg::PU_CYC,
  parameter int WR_CYCLES = see_pkg::WR_CYC,
  parameter bit HAS_ADDR_PINS = 1'b1,
  parameter bit HAS_WP_PIN = 1'b1,
  parameter bit FASTPLUS_REV = 1'b1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic link_clk,
  input wire see_pkg::see_pins_t pins,
  output logic sda_o,
  output logic sda_oe,
  output logic rx_valid,
  output see_pkg::see_rx_t rx_word,
  output logic wr_start,
  output logic write_busy,
  output logic ready,
  output logic rd_take,
  input wire logic [7:0] rd_data
);
  import see_pkg::*;

  localparam int PUW = $clog2(PU_CYCLES + 1);
  localparam int WRW = $clog2(WR_CYCLES + 1);
  localparam int SCL_MAX = FASTPLUS_REV ? FASTPLUS_SCL_HZ : FAST_SCL_HZ;

  // Fast-plus needs the link sampling clock well above the bus clock
  if (LINK_HZ / SCL_MAX < MIN_OVERSAMPLE || PU_CYCLES < 1 || WR_CYCLES < 1) begin : g_chk
    $error("see_bus_slave: unsupported rate or count"); // R1
  end

  function automatic logic addr_hit(input logic [7:0] b, input logic [2:0] s);
    addr_hit = (b[7:4] == DEV_CODE) && (b[3:1] == s); // R12
  endfunction

  // ************************************************************
  // Core clock domain: power-up and write-cycle timing
  // ************************************************************
  logic [PUW-1:0] pu_cnt_reg;
  logic ready_reg;
  logic [WRW-1:0] wr_cnt_reg;
  logic busy_reg;
  logic [2:0] wt_s_reg, rt_s_reg, tk_s_reg;
  logic [1:0] txa_s_reg;
  logic take_d_reg, rx_valid_reg, wr_start_reg;
  logic [7:0] rd_hold_reg;
  see_rx_t rx_out_reg;
  logic wr_ev, rx_ev, tk_ev;

  // Link-domain registers read across the crossing
  see_state_t st_reg;
  logic wr_tgl_reg, rx_tgl_reg, tk_tgl_reg;
  see_rx_t rx_hold_reg;

  assign wr_ev = wt_s_reg[1] ^ wt_s_reg[2];
  assign rx_ev = rt_s_reg[1] ^ rt_s_reg[2];
  assign tk_ev = tk_s_reg[1] ^ tk_s_reg[2];

  // Supply detector drives nrst; the ready delay restarts on every brown-out
  always_ff @(posedge clk) begin
    if (!nrst) begin // R3
      pu_cnt_reg <= '0;
      ready_reg <= 1'b0;
    end else if (ce && !ready_reg) begin
      if (pu_cnt_reg == PUW'(PU_CYCLES - 1)) ready_reg <= 1'b1; // R4
      pu_cnt_reg <= pu_cnt_reg + 1'b1;
    end
  end

  // Toggle synchronisers for events from the link side
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wt_s_reg <= '0;
      rt_s_reg <= '0;
      tk_s_reg <= '0;
      txa_s_reg <= '0;
    end else if (ce) begin
      wt_s_reg <= {wt_s_reg[1:0], wr_tgl_reg};
      rt_s_reg <= {rt_s_reg[1:0], rx_tgl_reg};
      tk_s_reg <= {tk_s_reg[1:0], tk_tgl_reg};
      txa_s_reg <= {txa_s_reg[0], (st_reg == ST_TX) || (st_reg == ST_TX_ACK)};
    end
  end

  // Internal write cycle timer, started by the stop or repeated start that ends a write
  always_ff @(posedge clk) begin
    if (!nrst) begin
      busy_reg <= 1'b0;
      wr_cnt_reg <= '0;
      wr_start_reg <= 1'b0;
    end else if (ce) begin
      wr_start_reg <= wr_ev;
      if (wr_ev) begin
        busy_reg <= 1'b1;
        wr_cnt_reg <= '0;
      end else if (busy_reg) begin
        if (wr_cnt_reg == WRW'(WR_CYCLES - 1)) busy_reg <= 1'b0; // R11
        wr_cnt_reg <= wr_cnt_reg + 1'b1;
      end
    end
  end

  // Received bytes and read data hand-off; the link word is stable for a whole byte
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rx_valid_reg <= 1'b0;
      rx_out_reg <= '0;
      rd_hold_reg <= 8'hFF;
      take_d_reg <= 1'b0;
    end else if (ce) begin
      rx_valid_reg <= rx_ev;
      if (rx_ev) rx_out_reg <= rx_hold_reg;
      take_d_reg <= tk_ev;
      // Only refreshed while the shifter is not loading from it
      if (!txa_s_reg[1] || take_d_reg) rd_hold_reg <= rd_data;
    end
  end

  assign rx_valid = rx_valid_reg;
  assign rx_word = rx_out_reg;
  assign wr_start = wr_start_reg;
  assign write_busy = busy_reg;
  assign ready = ready_reg;
  assign rd_take = take_d_reg;

  // ************************************************************
  // Link clock domain: synchronisers and glitch filter
  // ************************************************************
  see_pins_t pin_s1_reg, pin_s2_reg;
  logic [1:0] ctl_s1_reg, ctl_s2_reg;
  logic [1:0] st_s1_reg, st_s2_reg;
  logic lrst_n, ce_l, ready_l, busy_l;
  logic [1:0] raw, filt_reg, prev_reg;
  logic [3:0] fcnt_reg [2];
  logic scl_rise, scl_fall, start_c, stop_c, wp_eff;
  logic [2:0] sel;

  always_ff @(posedge link_clk) begin
    pin_s1_reg <= pins;
    pin_s2_reg <= pin_s1_reg;
    ctl_s1_reg <= {nrst, ce};
    ctl_s2_reg <= ctl_s1_reg;
    st_s1_reg <= {ready_reg, busy_reg};
    st_s2_reg <= st_s1_reg;
  end

  assign lrst_n = ctl_s2_reg[1];
  assign ce_l = ctl_s2_reg[0];
  assign ready_l = st_s2_reg[1];
  assign busy_l = st_s2_reg[0];
  assign raw = {pin_s2_reg.scl, pin_s2_reg.sda_in};
  assign sel = HAS_ADDR_PINS ? {pin_s2_reg.addr_select_bit2, pin_s2_reg.addr_select_bit1,
                                pin_s2_reg.addr_select_bit0} : FIXED_SEL; // R7 R8
  assign wp_eff = HAS_WP_PIN ? pin_s2_reg.wp : 1'b0; // R9 R10

  // A level is believed only after it has held longer than the filter width
  for (genvar i = 0; i < 2; i++) begin : g_filt
    always_ff @(posedge link_clk) begin
      if (!lrst_n) begin
        filt_reg[i] <= 1'b1;
        fcnt_reg[i] <= '0;
      end else if (ce_l) begin
        if (raw[i] == filt_reg[i]) fcnt_reg[i] <= '0;
        else if (fcnt_reg[i] == 4'(FILT_CYC - 1)) begin // R2
          filt_reg[i] <= raw[i];
          fcnt_reg[i] <= '0;
        end else fcnt_reg[i] <= fcnt_reg[i] + 4'h1;
      end
    end
  end

  always_ff @(posedge link_clk) begin
    if (!lrst_n) prev_reg <= 2'b11;
    else if (ce_l) prev_reg <= filt_reg;
  end

  assign scl_rise = filt_reg[1] && !prev_reg[1];
  assign scl_fall = !filt_reg[1] && prev_reg[1];
  assign start_c = filt_reg[1] && prev_reg[1] && prev_reg[0] && !filt_reg[0];
  assign stop_c = filt_reg[1] && prev_reg[1] && !prev_reg[0] && filt_reg[0];

  // ************************************************************
  // Link clock domain: byte engine
  // ************************************************************
  logic [3:0] cnt_reg;
  logic [7:0] sh_reg;
  logic [1:0] idx_reg;
  logic rw_reg, mack_reg, wp_lat_reg, wr_pend_reg, oe_reg;

  always_ff @(posedge link_clk) begin
    if (!lrst_n) begin
      st_reg <= ST_IDLE;
      cnt_reg <= '0;
      sh_reg <= '0;
      idx_reg <= '0;
      rw_reg <= 1'b0;
      mack_reg <= 1'b0;
      wp_lat_reg <= 1'b0;
      wr_pend_reg <= 1'b0;
      oe_reg <= 1'b0;
      rx_hold_reg <= '0;
      wr_tgl_reg <= 1'b0;
      rx_tgl_reg <= 1'b0;
      tk_tgl_reg <= 1'b0;
    end else if (ce_l) begin
      if (start_c || stop_c) begin
        // Start or stop ends any write; pending data begins the write cycle
        st_reg <= start_c ? ST_ADDR : ST_IDLE;
        cnt_reg <= '0;
        idx_reg <= '0;
        oe_reg <= 1'b0;
        if (wr_pend_reg) wr_tgl_reg <= !wr_tgl_reg; // R11
        wr_pend_reg <= 1'b0;
      end else begin
        unique case (st_reg)
          ST_IDLE: ;
          ST_ADDR, ST_RX: begin
            if (scl_rise && cnt_reg != BITS_PER_BYTE) begin
              sh_reg <= {sh_reg[6:0], filt_reg[0]}; // R6
              cnt_reg <= cnt_reg + 4'h1;
            end else if (scl_fall && cnt_reg == BITS_PER_BYTE) begin
              if (st_reg == ST_ADDR) begin
                if (addr_hit(sh_reg, sel) && ready_l && !busy_l) begin // R7 R14
                  oe_reg <= 1'b1; // R15
                  rw_reg <= sh_reg[0]; // R12
                  st_reg <= ST_ACK_ADDR;
                end else st_reg <= ST_IDLE;
              end else if (idx_reg == 2'(DATA_IDX) && wp_lat_reg) begin
                st_reg <= ST_IDLE; // R13
                wr_pend_reg <= 1'b0;
              end else begin
                oe_reg <= 1'b1; // R15
                st_reg <= ST_ACK_RX;
                rx_hold_reg <= '{data: sh_reg, is_data: idx_reg == 2'(DATA_IDX)};
                rx_tgl_reg <= !rx_tgl_reg;
                if (idx_reg == 2'(DATA_IDX)) wr_pend_reg <= 1'b1;
              end
            end
          end
          ST_ACK_ADDR, ST_ACK_RX, ST_TX_ACK: begin
            if (scl_rise) mack_reg <= !filt_reg[0];
            if (scl_fall) begin
              if ((st_reg == ST_ACK_ADDR && rw_reg) || (st_reg == ST_TX_ACK && mack_reg)) begin
                sh_reg <= rd_hold_reg;
                oe_reg <= !rd_hold_reg[7]; // R5 R6
                cnt_reg <= 4'h1;
                tk_tgl_reg <= !tk_tgl_reg;
                st_reg <= ST_TX;
              end else if (st_reg == ST_TX_ACK) begin
                st_reg <= ST_IDLE;
                oe_reg <= 1'b0;
              end else begin
                oe_reg <= 1'b0; // R15
                cnt_reg <= '0;
                st_reg <= ST_RX;
                if (st_reg == ST_ACK_RX && idx_reg == 2'(DATA_IDX - 1)) begin
                  wp_lat_reg <= wp_eff; // R13
                end
                if (st_reg == ST_ACK_RX && idx_reg != 2'(DATA_IDX)) idx_reg <= idx_reg + 2'h1;
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (cnt_reg == BITS_PER_BYTE) begin
                oe_reg <= 1'b0; // R15
                st_reg <= ST_TX_ACK;
              end else begin
                sh_reg <= {sh_reg[6:0], 1'b0};
                oe_reg <= !sh_reg[6]; // R5 R6
                cnt_reg <= cnt_reg + 4'h1;
              end
            end
          end
          default: st_reg <= ST_IDLE;
        endcase
      end
    end
  end

  // Open drain: the pin is only ever pulled low
  assign sda_o = 1'b0; // R5
  assign sda_oe = oe_reg;

  // ************************************************************
  // Checks
  // ************************************************************
  a_drive_states: assert property (@(posedge link_clk) disable iff (!lrst_n)
    sda_oe |-> st_reg inside {ST_ACK_ADDR, ST_ACK_RX, ST_TX}) // R5
    else $error("data line driven outside ack or transmit");
  a_busy_no_ack: assert property (@(posedge link_clk) disable iff (!lrst_n)
    ce_l && st_reg == ST_ADDR && cnt_reg == BITS_PER_BYTE && scl_fall && busy_l
      && !start_c && !stop_c |=> !sda_oe && st_reg == ST_IDLE) // R14
    else $error("address acknowledged during write cycle");
  a_sel_mismatch: assert property (@(posedge link_clk) disable iff (!lrst_n)
    ce_l && st_reg == ST_ADDR && cnt_reg == BITS_PER_BYTE && scl_fall
      && sh_reg[3:1] != sel && !start_c && !stop_c |=> st_reg == ST_IDLE) // R7
    else $error("foreign select bits answered");
  a_wp_reject: assert property (@(posedge link_clk) disable iff (!lrst_n)
    ce_l && st_reg == ST_RX && cnt_reg == BITS_PER_BYTE && scl_fall && wp_lat_reg
      && idx_reg == 2'(DATA_IDX) && !start_c && !stop_c |=> !sda_oe && !wr_pend_reg) // R13
    else $error("protected data byte acknowledged");
  a_rise_sample: assert property (@(posedge link_clk) disable iff (!lrst_n)
    ce_l && st_reg == ST_RX && scl_rise && cnt_reg < BITS_PER_BYTE && !start_c && !stop_c
      |=> sh_reg[0] == $past(filt_reg[0])) // R6
    else $error("data not taken on clock rise");
  a_filter_hold: assert property (@(posedge link_clk) disable iff (!lrst_n)
    ce_l && $changed(filt_reg[1]) |-> $past(raw[1]) == filt_reg[1]) // R2
    else $error("filtered clock moved without a settled input");
  a_fixed_sel: assert property (@(posedge link_clk) disable iff (!lrst_n)
    !HAS_ADDR_PINS |-> sel == FIXED_SEL) // R8
    else $error("select taken from pins in pinless variant");
  a_wp_absent: assert property (@(posedge link_clk) disable iff (!lrst_n)
    !HAS_WP_PIN |-> !wp_lat_reg) // R10
    else $error("protect latched in variant without pin");
  a_wr_bound: assert property (@(posedge clk) disable iff (!nrst)
    busy_reg |-> wr_cnt_reg < WRW'(WR_CYCLES)) // R11
    else $error("write cycle overran");
  a_ready_time: assert property (@(posedge clk) disable iff (!nrst)
    $rose(ready_reg) |-> $past(pu_cnt_reg) == PUW'(PU_CYCLES - 1)) // R4
    else $error("ready at wrong time");
  a_reset_hold: assert property (@(posedge clk)
    !nrst |=> !ready_reg && !busy_reg) // R3
    else $error("not held in reset");

endmodule

// ==== testbench/see_bus_master_model.sv ====
// Two-wire bus master model that clocks the serial memory slave
module see_bus_master_model (
  input wire logic clk,
  output logic scl,
  output logic sda_m,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************************
  // Bus phases, 800 ns half period keeps well inside the speed class
  // ************************************************************
  localparam int HALF = 40;
  // Bus idles released, clock stands high between frames
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  // Wait a number of core clocks
  task automatic half(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Data changes 10 clocks into the low phase so it never races the clock edge
  task automatic start();
    half(10);
    sda_m <= 1'b1;
    half(HALF);
    scl <= 1'b1;
    half(HALF);
    sda_m <= 1'b0;
    half(HALF);
    scl <= 1'b0;
  endtask
  // Stop: data rises while clock is high
  task automatic stop();
    half(10);
    sda_m <= 1'b0;
    half(HALF);
    scl <= 1'b1;
    half(HALF);
    sda_m <= 1'b1;
    half(HALF);
  endtask
  // Send a byte MSB first, optionally with a 100 ns clock spike, then read ack
  task automatic wbyte(input logic [7:0] b, input logic glitch, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      half(10);
      sda_m <= b[i];
      if (glitch && i == 3) begin
        half(10);
        scl <= 1'b1;
        half(5);
        scl <= 1'b0;
        half(HALF - 25);
      end else begin
        half(HALF - 10);
      end
      scl <= 1'b1;
      half(HALF);
      scl <= 1'b0;
    end
    half(10);
    sda_m <= 1'b1;
    half(HALF - 10);
    scl <= 1'b1;
    half(HALF / 2);
    ack = (sda === 1'b0);
    half(HALF / 2);
    scl <= 1'b0;
  endtask
  // Receive a byte sampled mid-high, then answer ack or not
  task automatic rbyte(input logic ack_out, output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      half(HALF);
      scl <= 1'b1;
      half(HALF / 2);
      b[i] = sda;
      half(HALF / 2);
      scl <= 1'b0;
    end
    half(10);
    sda_m <= ~ack_out;
    half(HALF - 10);
    scl <= 1'b1;
    half(HALF);
    scl <= 1'b0;
  endtask
endmodule

// ==== testbench/serial_eeprom_bus_slave_tb.sv ====
// Self-checking bench for the serial memory bus slave
module serial_eeprom_bus_slave_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************************
  // Setup
  // ************************************************************
  localparam int PU = 20;
  localparam int WR = 2000;
  localparam int LIMIT = 60000;
  localparam logic [2:0] STRAP = 3'h5;
  logic clk, link_clk, nrst, wp, scl, sda_m, sda;
  logic [7:0] rd_data;
  logic sda_o, sda_oe, sda_oe2, rx_valid, wr_start, wr_start2, write_busy, ready, rd_take;
  see_pkg::see_rx_t rx_word, last_rx;
  see_pkg::see_pins_t pins;
  int num_errors = 0, check_count = 0, cyc = 0, ws_n = 0, ws2_n = 0, busy_n = 0, tk_n = 0;
  // Pull-up bus: any low driver wins
  assign sda = sda_m & ~sda_oe & ~sda_oe2;
  assign pins = {scl, sda, wp, STRAP};
  // Core clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Link sampling clock, phase unrelated to the core clock
  initial begin
    link_clk = 1'b0;
    #37;
    forever #62.5 link_clk = ~link_clk;
  end
  see_bus_slave #(.PU_CYCLES(PU), .WR_CYCLES(WR)) u_dut (
    .clk(clk), .nrst(nrst), .ce(1'b1), .link_clk(link_clk), .pins(pins), .sda_o(sda_o),
    .sda_oe(sda_oe), .rx_valid(rx_valid), .rx_word(rx_word), .wr_start(wr_start),
    .write_busy(write_busy), .ready(ready), .rd_take(rd_take), .rd_data(rd_data));
  // Variant without strap or protect pins shares the bus at select 000
  see_bus_slave #(.PU_CYCLES(PU), .WR_CYCLES(WR), .HAS_ADDR_PINS(1'b0), .HAS_WP_PIN(1'b0))
    u_dut2 (.clk(clk), .nrst(nrst), .ce(1'b1), .link_clk(link_clk), .pins(pins), .sda_o(),
    .sda_oe(sda_oe2), .rx_valid(), .rx_word(), .wr_start(wr_start2), .write_busy(),
    .ready(), .rd_take(), .rd_data(8'h00));
  see_bus_master_model u_master (.clk(clk), .scl(scl), .sda_m(sda_m), .sda(sda));
  // Event counters and the hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    ws_n <= ws_n + int'(wr_start);
    ws2_n <= ws2_n + int'(wr_start2);
    busy_n <= busy_n + int'(write_busy);
    tk_n <= tk_n + int'(rd_take);
    if (rx_valid) last_rx <= rx_word;
    if (cyc == LIMIT) begin
      num_errors++;
      summarize();
    end
  end
  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    if (num_errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic open(input logic [2:0] sel, input logic rw, output logic ack);
    u_master.start();
    u_master.wbyte({4'hA, sel, rw}, 1'b0, ack);
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  // Ready must follow reset release after the power-up delay; master waits for it
  task automatic t_ready();
    int n = 0;
    chk(16'(ready), 16'h0000);
    while (ready !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk(16'(n >= PU - 1 && n <= PU + 2), 16'h0001);
  endtask
  // Every select value, plus a wrong fixed pattern
  task automatic t_addr();
    logic ack;
    for (int s = 0; s < 8; s++) begin
      open(3'(s), 1'b0, ack);
      u_master.stop();
      chk(16'(ack), 16'(3'(s) == STRAP || s == 0));
    end
    u_master.start();
    u_master.wbyte({4'hB, STRAP, 1'b0}, 1'b0, ack);
    u_master.stop();
    chk(16'(ack), 16'h0000);
  endtask
  // Byte write with a clock spike, poll during the internal write, time it
  task automatic t_write();
    logic a0, a1, a2, a3;
    int ws0 = ws_n, b0 = busy_n, n = 0;
    open(STRAP, 1'b0, a0);
    u_master.wbyte(8'h00, 1'b1, a1);
    u_master.wbyte(8'h10, 1'b0, a2);
    u_master.wbyte(8'h5A, 1'b0, a3);
    chk({12'h0, a0, a1, a2, a3}, 16'h000F);
    chk(16'(last_rx), 16'h00B5);
    u_master.stop();
    while (ws_n == ws0 && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk(16'(ws_n - ws0), 16'h0001);
    open(STRAP, 1'b0, a0);
    u_master.stop();
    chk(16'(a0), 16'h0000);
    n = 0;
    while (write_busy !== 1'b0 && n < WR + 100) begin
      @(posedge clk);
      n++;
    end
    repeat (2) @(posedge clk);
    chk(16'(busy_n - b0), 16'(WR));
  endtask
  // Protect high: strapped part refuses the data byte, pinless part accepts
  task automatic t_wp();
    logic a0, a1, a2, a3;
    int ws0 = ws_n, ws20 = ws2_n;
    wp <= 1'b1;
    for (int d = 0; d < 2; d++) begin
      open(d == 0 ? STRAP : 3'h0, 1'b0, a0);
      u_master.wbyte(8'h00, 1'b0, a1);
      u_master.wbyte(8'h20, 1'b0, a2);
      u_master.wbyte(8'hC3, 1'b0, a3);
      u_master.stop();
      chk({12'h0, a0, a1, a2, a3}, d == 0 ? 16'h000E : 16'h000F);
    end
    repeat (100) @(posedge clk);
    chk(16'(ws_n - ws0), 16'h0000);
    chk(16'(ws2_n - ws20), 16'h0001);
    wp <= 1'b0;
  endtask
  // Read one byte: ones are sent by releasing the line
  task automatic t_read();
    logic a0;
    logic [7:0] b;
    int tk0 = tk_n;
    open(STRAP, 1'b1, a0);
    u_master.rbyte(1'b0, b);
    u_master.stop();
    chk(16'(a0), 16'h0001);
    chk(16'(b), 16'h0096);
    chk(16'(sda_o), 16'h0000);
    chk(16'(tk_n - tk0), 16'h0001);
  endtask
  // Brown-out in mid-run: back to reset, then standby again
  task automatic t_reset();
    nrst <= 1'b0;
    repeat (24) @(posedge clk);
    chk({14'h0, ready, sda_oe}, 16'h0000);
    nrst <= 1'b1;
    t_ready();
  endtask
  // Main sequence; reset held long enough to cross into the link domain
  initial begin
    nrst = 1'b0;
    wp = 1'b0;
    rd_data = 8'h96;
    repeat (24) @(posedge clk);
    nrst <= 1'b1;
    t_ready();
    t_addr();
    t_write();
    t_wp();
    t_read();
    t_reset();
    t_read();
    summarize();
  end
endmodule
